//--- rtl/adc_seq_pkg.sv
package adc_seq_pkg;
	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_ACTIVE_ITEM_TRIGGER = 10'h01a;
	localparam logic [9:0] IDX_PREFETCH_ADDRESS = 10'h01c;
	localparam logic [9:0] IDX_COMPLETED_LIST_ADDRESS = 10'h01e;
	localparam logic [9:0] IDX_SEQUENCER_STATE = 10'h020;
	localparam logic [9:0] IDX_DEAD_TIME_WAIT_CFG1 = 10'h022;
	localparam logic [9:0] IDX_DEAD_TIME_WAIT_CFG2 = 10'h024;
	localparam logic [9:0] IDX_TARGET_ADDRESS_CONTENT = 10'h026;
	localparam logic [9:0] IDX_PHASE_CHANNEL_SELECT = 10'h028;
	localparam logic [9:0] IDX_INTERRUPT_FLAGS = 10'h070;
	localparam logic [9:0] IDX_INTERRUPT_SOURCE_MASK = 10'h074;
	localparam logic [9:0] IDX_VECTOR_ENABLE = 10'h078;
	localparam logic [9:0] IDX_VECTOR_DISABLE = 10'h07a;
	localparam logic [9:0] IDX_NESTING_VECTOR_LIMIT = 10'h07c;
	localparam logic [9:0] IDX_PENDING_VECTOR_NUMBER = 10'h07e;

	// flag positions
	localparam int FLAG_RANGE_FAIL_0 = 6;
	localparam int FLAG_ADDR_FREE = 5;
	localparam int FLAG_DONE_NEMPTY = 4;
	localparam int FLAG_LIST_DONE = 3;
	localparam int FLAG_SUM_WRITTEN = 2;
	localparam int FLAG_WRITE_ERR = 1;
	localparam int FLAG_READ_ERR = 0;
	localparam int NUM_VECTORS = 16;

	// field positions of the phase channel register
	localparam int PHASE_A_LSB = 0;
	localparam int PHASE_B_LSB = 5;
	localparam int PHASE_C_LSB = 10;

	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_WAIT = 8'h00;
	localparam logic [4:0] RST_VMAX = 5'h00;
	localparam logic [4:0] NO_PENDING_VNO = 5'h10;
	localparam logic [15:0] SKIP_MARKER = 16'hffff;

	localparam logic [4:0] CH_AUTO_A = 5'h1c;
	localparam logic [4:0] CH_AUTO_B = 5'h1d;
	localparam logic [4:0] CH_AUTO_C = 5'h1e;

	localparam logic [1:0] PHASE_A = 2'h0;
	localparam logic [1:0] PHASE_B = 2'h1;
	localparam logic [1:0] PHASE_C = 2'h2;

	localparam logic [1:0] DT_CFG_1 = 2'h1;
	localparam logic [1:0] DT_CFG_2 = 2'h2;

	typedef enum logic [2:0] {
		SEQ_IDLE = 3'b000,
		SEQ_WAIT_TRIGGER = 3'b001,
		SEQ_SAMPLING = 3'b010,
		SEQ_OTHER_CMD = 3'b011,
		SEQ_WAIT_ITEM = 3'b100,
		SEQ_FINISH = 3'b101
	} seq_state_t;
endpackage

//--- rtl/adc_seq_status.sv
// Added by the designer: the APB register port.
`timescale 1ns/100ps
//Overview of operation
// [R01] active list item trigger field readable, read-only
// [R02] last prefetched SRAM address readable; not the active sequence
// [R03] start address of last completed or goto list captured, readable
// [R04] reading completed-list address clears the done-address-not-empty flag
// [R05] skip-list termination updates neither completed address nor its flag
// [R06] sequencer state shown as 3-bit code 0..5
// [R07] dead-time configs one and two wait programmable 8-bit cycle count
// [R08] 16-bit target address read/write, also loadable by list command
// [R09] auto-channel edge triggers pick phase A, B or C field
// [R10] channels 28, 29, 30 convert phase A, B, C field channel
// [R11] ten range-fail flags in bits 15..6 set by compare commands
// [R12] bit 5 new start address acceptable; bit 4 completed address waiting
// [R13] bit 3 set on list done, bit 2 on sum written
// [R14] write error flagged and address skipped when a sum cannot be written
// [R15] read error when next item late after a converting item
// [R16] each source raises interrupts only while its mask bit is one
// [R17] vector enable and disable registers switch single vectors
// [R18] only vectors below the software maximum may nest
// [R19] vector number read gives lowest enabled pending or first unused
// [R20] writing vector number clears that vector's pending event
// [R21] sums written only inside lower and upper protection bounds
// [R22] missed dead-time trigger skips item, stores marker once, write error
// [R23] interrupt output while an enabled pending vector lies below maximum
module adc_seq_status
	import adc_seq_pkg::*;
#(
	parameter int WAIT_W = 8
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [15:0] i_item_trigger,
	input wire logic [15:0] i_prefetch_addr,
	input wire logic [15:0] i_list_start_addr,
	input wire logic i_list_done,
	input wire logic i_list_goto,
	input wire logic i_list_skip,
	input wire logic [2:0] i_seq_state,
	input wire logic i_dt_event,
	input wire logic [1:0] i_dt_cfg,
	input wire logic [WAIT_W-1:0] i_dt_wait0,
	output logic o_sample_start,
	input wire logic i_tadr_load,
	input wire logic [15:0] i_tadr_value,
	output logic [15:0] o_target_addr,
	input wire logic i_ch_req,
	input wire logic [4:0] i_ch_no,
	input wire logic i_edge_trig,
	input wire logic i_auto_bit,
	input wire logic [1:0] i_edge_phase,
	output logic [4:0] o_conv_channel,
	input wire logic i_sum_req,
	input wire logic [15:0] i_sum_addr,
	input wire logic [10:0] i_wadr_min,
	input wire logic [10:0] i_wadr_max,
	output logic o_sum_write,
	output logic o_addr_skip,
	input wire logic i_fifo_overflow,
	input wire logic i_missed_trig_en,
	input wire logic i_missed_dt_trigger,
	input wire logic [4:0] i_no_sum,
	output logic o_marker_store,
	output logic [15:0] o_marker_data,
	input wire logic i_sum_written,
	input wire logic i_next_item_late,
	input wire logic i_prev_had_conv,
	input wire logic [9:0] i_range_fail,
	input wire logic i_new_addr_free,
	output logic o_irq
);
	irq_vec_if vbus();

	logic ack_reg;
	logic [31:0] prdata_reg;
	logic [9:0] idx;
	logic hit;
	logic [15:0] rd_data;
	logic wr_fire;
	logic rd_fire;
	logic rd_first;

	logic [15:0] trigger_reg;
	logic [15:0] prefetch_reg;
	logic [15:0] completed_reg;
	seq_state_t state_reg;
	logic [WAIT_W-1:0] wait1_reg;
	logic [WAIT_W-1:0] wait2_reg;
	logic [15:0] tadr_reg;
	logic [14:0] phase_sel_reg;
	logic [15:0] flag_reg;
	logic [15:0] mask_reg;
	logic [4:0] vmax_reg;
	logic irq_reg;

	logic [WAIT_W-1:0] dt_cnt_reg;
	logic dt_busy_reg;
	logic start_reg;
	logic [WAIT_W-1:0] wait_sel;
	logic [4:0] channel_reg;
	logic [4:0] channel_next;
	logic sum_write_reg;
	logic skip_reg;
	logic marker_reg;

	logic [15:0] ev;
	logic [15:0] clr;
	logic [15:0] w1c;
	logic [15:0] vno_clr;
	logic capture_done;
	logic in_range;
	logic range_bad;
	logic missed;

	assign idx = i_paddr[11:2];
	// one wait state: data is registered in the first access cycle
	assign rd_first = i_psel & i_penable & ~ack_reg & ~i_pwrite;
	assign o_pready = i_psel & i_penable & ack_reg;
	assign o_pslverr = o_pready & ~hit;
	assign wr_fire = o_pready & i_pwrite & hit;
	assign rd_fire = o_pready & ~i_pwrite & hit;
	assign o_prdata = prdata_reg;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= i_psel & i_penable & ~ack_reg;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prdata_reg <= 32'h00000000;
		end else if (rd_first) begin
			prdata_reg <= {16'h0000, rd_data};
		end
	end

	always_comb begin
		rd_data = RST_WORD;
		hit = (i_paddr[1:0] == 2'b00);
		case (idx)
			IDX_ACTIVE_ITEM_TRIGGER: rd_data = trigger_reg; // R01
			IDX_PREFETCH_ADDRESS: rd_data = prefetch_reg; // R02
			IDX_COMPLETED_LIST_ADDRESS: rd_data = completed_reg; // R03
			IDX_SEQUENCER_STATE: rd_data = {13'h0000, state_reg}; // R06
			IDX_DEAD_TIME_WAIT_CFG1: rd_data = 16'(wait1_reg);
			IDX_DEAD_TIME_WAIT_CFG2: rd_data = 16'(wait2_reg);
			IDX_TARGET_ADDRESS_CONTENT: rd_data = tadr_reg; // R08
			IDX_PHASE_CHANNEL_SELECT: rd_data = {1'b0, phase_sel_reg};
			IDX_INTERRUPT_FLAGS: rd_data = flag_reg; // R12
			IDX_INTERRUPT_SOURCE_MASK: rd_data = mask_reg;
			IDX_VECTOR_ENABLE: rd_data = RST_WORD;
			IDX_VECTOR_DISABLE: rd_data = RST_WORD;
			IDX_NESTING_VECTOR_LIMIT: rd_data = {11'h000, vmax_reg};
			IDX_PENDING_VECTOR_NUMBER: rd_data = {11'h000, vbus.lowest}; // R19
			default: hit = 1'b0;
		endcase
	end

	// live read-back of the sequencer's own registers
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trigger_reg <= RST_WORD;
			prefetch_reg <= RST_WORD;
			state_reg <= SEQ_IDLE;
		end else begin
			trigger_reg <= i_item_trigger; // R01
			prefetch_reg <= i_prefetch_addr; // R02
			state_reg <= seq_state_t'(i_seq_state); // R06
		end
	end

	// skip termination never feeds the completed address
	assign capture_done = (i_list_done | i_list_goto) & ~i_list_skip; // R05

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			completed_reg <= RST_WORD;
		end else if (capture_done) begin
			completed_reg <= i_list_start_addr; // R03
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wait1_reg <= RST_WAIT;
			wait2_reg <= RST_WAIT;
			phase_sel_reg <= 15'h0000;
			mask_reg <= RST_WORD;
			vmax_reg <= RST_VMAX;
		end else if (wr_fire) begin
			case (idx)
				IDX_DEAD_TIME_WAIT_CFG1: wait1_reg <= i_pwdata[WAIT_W-1:0];
				IDX_DEAD_TIME_WAIT_CFG2: wait2_reg <= i_pwdata[WAIT_W-1:0];
				IDX_PHASE_CHANNEL_SELECT: phase_sel_reg <= i_pwdata[14:0];
				IDX_INTERRUPT_SOURCE_MASK: mask_reg <= i_pwdata[15:0]; // R16
				IDX_NESTING_VECTOR_LIMIT: vmax_reg <= i_pwdata[4:0]; // R18
				default: ;
			endcase
		end
	end

	// list command load has priority over a software write
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tadr_reg <= RST_WORD;
		end else if (i_tadr_load) begin
			tadr_reg <= i_tadr_value; // R08
		end else if (wr_fire && idx == IDX_TARGET_ADDRESS_CONTENT) begin
			tadr_reg <= i_pwdata[15:0]; // R08
		end
	end
	assign o_target_addr = tadr_reg;

	// dead-time wait: start pulse follows the event by wait+1 cycles
	always_comb begin
		wait_sel = i_dt_wait0;
		if (i_dt_cfg == DT_CFG_1) begin
			wait_sel = wait1_reg; // R07
		end else if (i_dt_cfg == DT_CFG_2) begin
			wait_sel = wait2_reg; // R07
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dt_cnt_reg <= RST_WAIT;
			dt_busy_reg <= 1'b0;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (i_dt_event) begin
				if (wait_sel == '0) begin
					start_reg <= 1'b1; // R07
					dt_busy_reg <= 1'b0;
				end else begin
					dt_cnt_reg <= wait_sel - 1'b1; // R07
					dt_busy_reg <= 1'b1;
				end
			end else if (dt_busy_reg) begin
				if (dt_cnt_reg == '0) begin
					start_reg <= 1'b1; // R07
					dt_busy_reg <= 1'b0;
				end else begin
					dt_cnt_reg <= dt_cnt_reg - 1'b1;
				end
			end
		end
	end
	assign o_sample_start = start_reg;

	// channel choice for the next conversion
	always_comb begin
		channel_next = i_ch_no;
		if (i_edge_trig && i_auto_bit) begin
			unique case (i_edge_phase)
				PHASE_A: channel_next = phase_sel_reg[PHASE_A_LSB +: 5]; // R09
				PHASE_B: channel_next = phase_sel_reg[PHASE_B_LSB +: 5]; // R09
				PHASE_C: channel_next = phase_sel_reg[PHASE_C_LSB +: 5]; // R09
				default: channel_next = i_ch_no;
			endcase
		end else if (i_ch_no == CH_AUTO_A) begin
			channel_next = phase_sel_reg[PHASE_A_LSB +: 5]; // R10
		end else if (i_ch_no == CH_AUTO_B) begin
			channel_next = phase_sel_reg[PHASE_B_LSB +: 5]; // R10
		end else if (i_ch_no == CH_AUTO_C) begin
			channel_next = phase_sel_reg[PHASE_C_LSB +: 5]; // R10
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			channel_reg <= 5'h00;
		end else if (i_ch_req) begin
			channel_reg <= channel_next;
		end
	end
	assign o_conv_channel = channel_reg;

	// write protection window and write error causes
	assign in_range = (i_sum_addr >= {i_wadr_min, 5'h00})
		&& (i_sum_addr < {i_wadr_max, 5'h00}); // R21
	assign range_bad = i_sum_req & ~in_range; // R21
	assign missed = i_missed_trig_en & i_missed_dt_trigger
		& (i_no_sum != 5'h00); // R22

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sum_write_reg <= 1'b0;
			skip_reg <= 1'b0;
			marker_reg <= 1'b0;
		end else begin
			sum_write_reg <= i_sum_req & in_range & ~i_fifo_overflow; // R21
			skip_reg <= range_bad | i_fifo_overflow | missed; // R14
			marker_reg <= missed; // R22
		end
	end
	assign o_sum_write = sum_write_reg;
	assign o_addr_skip = skip_reg;
	assign o_marker_store = marker_reg;
	assign o_marker_data = SKIP_MARKER;

	// flag events; a set in the same cycle as a clear wins
	always_comb begin
		ev = RST_WORD;
		ev[15:FLAG_RANGE_FAIL_0] = i_range_fail; // R11
		ev[FLAG_ADDR_FREE] = i_new_addr_free; // R12
		ev[FLAG_DONE_NEMPTY] = capture_done; // R05 R12
		ev[FLAG_LIST_DONE] = i_list_done & ~i_list_skip; // R13
		ev[FLAG_SUM_WRITTEN] = i_sum_written; // R13
		ev[FLAG_WRITE_ERR] = range_bad | i_fifo_overflow | missed; // R14 R22
		ev[FLAG_READ_ERR] = i_next_item_late & i_prev_had_conv; // R15
	end

	always_comb begin
		w1c = RST_WORD;
		vno_clr = RST_WORD;
		if (wr_fire && idx == IDX_INTERRUPT_FLAGS) begin
			w1c = i_pwdata[15:0];
		end
		if (wr_fire && idx == IDX_PENDING_VECTOR_NUMBER && !i_pwdata[4]) begin
			vno_clr[i_pwdata[3:0]] = 1'b1; // R20
		end
		clr = w1c | vno_clr;
		clr[FLAG_ADDR_FREE] = 1'b1;
		clr[FLAG_DONE_NEMPTY] = vno_clr[FLAG_DONE_NEMPTY]
			| (rd_fire && idx == IDX_COMPLETED_LIST_ADDRESS); // R04
	end

	for (genvar i = 0; i < NUM_VECTORS; i++) begin : g_flag
		always_ff @(posedge i_clock or negedge i_rst_b) begin
			if (!i_rst_b) begin
				flag_reg[i] <= 1'b0;
			end else begin
				flag_reg[i] <= ev[i] | (flag_reg[i] & ~clr[i]);
			end
		end
	end

	assign vbus.status = flag_reg;
	assign vbus.mask = mask_reg;
	assign vbus.vmax = vmax_reg;
	assign vbus.wr_vno = i_pwdata[3:0];
	assign vbus.en_wr = wr_fire && idx == IDX_VECTOR_ENABLE; // R17
	assign vbus.dis_wr = wr_fire && idx == IDX_VECTOR_DISABLE; // R17

	irq_vector_ctrl u_vec (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.bus(vbus.vec)
	);

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= vbus.irq; // R23
		end
	end
	assign o_irq = irq_reg;
endmodule

//--- rtl/irq_vec_if.sv
`timescale 1ns/100ps
interface irq_vec_if;
	logic [15:0] status;
	logic [15:0] mask;
	logic en_wr;
	logic dis_wr;
	logic [3:0] wr_vno;
	logic [4:0] vmax;
	logic [4:0] lowest;
	logic irq;

	modport ctrl (
		output status, mask, en_wr, dis_wr, wr_vno, vmax,
		input lowest, irq
	);
	modport vec (
		input status, mask, en_wr, dis_wr, wr_vno, vmax,
		output lowest, irq
	);
endinterface

//--- rtl/irq_vector_ctrl.sv
`timescale 1ns/100ps
module irq_vector_ctrl
	import adc_seq_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	irq_vec_if.vec bus
);
	logic [15:0] venable_reg;
	logic [15:0] pending;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			venable_reg <= RST_WORD;
		end else if (bus.en_wr) begin
			venable_reg[bus.wr_vno] <= 1'b1; // R17
		end else if (bus.dis_wr) begin
			venable_reg[bus.wr_vno] <= 1'b0; // R17
		end
	end

	// pending needs source flag, source mask and vector enable
	assign pending = bus.status & bus.mask & venable_reg; // R16

	always_comb begin
		bus.lowest = NO_PENDING_VNO;
		bus.irq = 1'b0;
		for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
			if (pending[i]) begin
				bus.lowest = 5'(i); // R19
				if (5'(i) < bus.vmax) begin
					bus.irq = 1'b1; // R18 R23
				end
			end
		end
	end
endmodule

//--- sim/adc_seq_status_monitor.sv
`timescale 1ns/100ps
module adc_seq_status_monitor
	import adc_seq_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_pwrite,
	input wire logic i_tadr_load,
	input wire logic [15:0] i_tadr_value,
	input wire logic [15:0] o_target_addr,
	input wire logic i_sum_req,
	input wire logic [15:0] i_sum_addr,
	input wire logic [10:0] i_wadr_min,
	input wire logic [10:0] i_wadr_max,
	input wire logic i_fifo_overflow,
	input wire logic o_sum_write,
	input wire logic o_addr_skip,
	input wire logic i_missed_trig_en,
	input wire logic i_missed_dt_trigger,
	input wire logic [4:0] i_no_sum,
	input wire logic o_marker_store,
	input wire logic [15:0] o_marker_data
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	logic inr;
	logic miss;
	assign inr = i_sum_addr >= {i_wadr_min, 5'h00}
		&& i_sum_addr < {i_wadr_max, 5'h00};
	assign miss = i_missed_trig_en && i_missed_dt_trigger && i_no_sum != 5'h00;

	a_sum_inside: assert property (
		i_sum_req && inr && !i_fifo_overflow && !miss
		|=> o_sum_write && !o_addr_skip) else $error("sum not written");
	a_sum_refused: assert property (
		i_sum_req && (!inr || i_fifo_overflow)
		|=> o_addr_skip && !o_sum_write) else $error("bad sum not skipped");
	a_write_cause: assert property (
		o_sum_write |-> $past(i_sum_req) && $past(inr))
		else $error("write without valid request");
	a_marker_once: assert property (
		miss |=> o_marker_store && o_addr_skip) else $error("no marker");
	a_marker_cause: assert property (
		o_marker_store |-> $past(miss)) else $error("spurious marker");
	a_marker_value: assert property (
		o_marker_data == SKIP_MARKER) else $error("marker value wrong");
	a_target_load: assert property (
		i_tadr_load |=> o_target_addr == $past(i_tadr_value))
		else $error("target not loaded");
	a_target_hold: assert property (
		!i_tadr_load && !(i_psel && i_pwrite) |=> $stable(o_target_addr))
		else $error("target changed");
	cover property (o_sum_write);
	cover property (o_marker_store);
	cover property (i_tadr_load);
endmodule

//--- sim/adc_seq_status_tb.sv
`timescale 1ns/100ps
module adc_seq_status_tb;
	import adc_seq_pkg::*;
	logic i_clock = 1'h0;
	logic i_rst_b = 1'h0;
	logic i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0;
	logic i_dt_event = 1'h0, i_tadr_load = 1'h0, i_ch_req = 1'h0;
	logic i_edge_trig = 1'h0, i_auto_bit = 1'h0, i_missed_trig_en = 1'h0;
	logic i_sum_written = 1'h0, i_next_item_late = 1'h0;
	logic i_prev_had_conv = 1'h0, i_new_addr_free = 1'h1;
	logic [1:0] i_dt_cfg = 2'h0, i_edge_phase = 2'h0;
	logic [7:0] i_dt_wait0 = 8'h00;
	logic [15:0] i_tadr_value = 16'h0000;
	logic [4:0] i_ch_no = 5'h00;
	logic [10:0] i_wadr_min = 11'h010, i_wadr_max = 11'h020;
	logic [9:0] i_range_fail = 10'h000;
	logic [31:0] o_prdata;
	logic o_pready, o_pslverr, o_sample_start, o_sum_write, o_addr_skip;
	logic o_marker_store, o_irq;
	logic [15:0] o_target_addr, o_marker_data;
	logic [4:0] o_conv_channel;
	logic [32:0] rq[$];
	logic [2:0] pq[$];
	logic [15:0] sadr[5] = '{16'h01ff, 16'h0200, 16'h03ff, 16'h0400, 16'h0300};
	logic [15:0] r, a;
	int error_cnt = 0, checked = 0, cyc = 0, n;

	seq_far_side seq_far_side_i (.i_clock);
	adc_seq_status adc_seq_status_i (
		.i_clock, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_item_trigger(seq_far_side_i.trig),
		.i_prefetch_addr(seq_far_side_i.pref),
		.i_list_start_addr(seq_far_side_i.sa),
		.i_list_done(seq_far_side_i.dn), .i_list_goto(seq_far_side_i.go),
		.i_list_skip(seq_far_side_i.sk), .i_seq_state(seq_far_side_i.st),
		.i_dt_event, .i_dt_cfg, .i_dt_wait0, .o_sample_start, .i_tadr_load,
		.i_tadr_value, .o_target_addr, .i_ch_req, .i_ch_no, .i_edge_trig,
		.i_auto_bit, .i_edge_phase, .o_conv_channel,
		.i_sum_req(seq_far_side_i.req), .i_sum_addr(seq_far_side_i.addr),
		.i_wadr_min, .i_wadr_max, .o_sum_write, .o_addr_skip,
		.i_fifo_overflow(seq_far_side_i.ovf), .i_missed_trig_en,
		.i_missed_dt_trigger(seq_far_side_i.miss),
		.i_no_sum(seq_far_side_i.nsum), .o_marker_store, .o_marker_data,
		.i_sum_written, .i_next_item_late, .i_prev_had_conv, .i_range_fail,
		.i_new_addr_free, .o_irq
	);

	initial forever #25 i_clock = ~i_clock;

	task chk(string s, logic [32:0] e, logic [32:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask

	task complete_run;
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task apb(logic w, logic [11:0] ad, logic [31:0] d);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= ad;
		i_pwdata <= d;
		@(posedge i_clock) i_penable <= 1'h1;
		do @(negedge i_clock); while (o_pready !== 1'h1);
		@(posedge i_clock) i_psel <= 1'h0;
		i_penable <= 1'h0;
		@(posedge i_clock);
	endtask

	task wr(logic [11:0] ad, logic [15:0] d);
		apb(1'h1, ad, {16'h0, d});
	endtask

	task rd(logic [11:0] ad, logic [15:0] e);
		rq.push_back({17'h0, e});
		apb(1'h0, ad, 32'h0);
	endtask

	task rde(logic [11:0] ad, logic [15:0] e);
		rq.push_back({17'h10000, e});
		apb(1'h0, ad, 32'h0);
	endtask

	task ev(logic [9:0] rf, logic lt, logic pc);
		i_range_fail <= rf;
		i_sum_written <= 1'h1;
		i_next_item_late <= lt;
		i_prev_had_conv <= pc;
		@(posedge i_clock) i_range_fail <= 10'h000;
		i_sum_written <= 1'h0;
		i_next_item_late <= 1'h0;
		@(posedge i_clock);
	endtask

	task irqchk(logic e);
		@(negedge i_clock) chk("irq", e, o_irq);
		@(posedge i_clock);
	endtask

	// results appear one at a time and are matched against the oldest note
	always @(negedge i_clock) begin
		if (i_psel && i_penable && !i_pwrite && o_pready !== 1'h0)
			chk("read", rq.pop_front(), {o_pslverr, o_prdata});
		if ((o_sum_write | o_addr_skip | o_marker_store) !== 1'h0)
			chk("sum", pq.pop_front(), {o_sum_write, o_addr_skip, o_marker_store});
		cyc++;
		if (cyc == 10000) begin
			error_cnt++;
			complete_run;
		end
	end

	initial begin
		void'($urandom(32'h22b1f7a1));
		repeat (10) @(posedge i_clock);
		i_rst_b <= 1'h1;
		@(posedge i_clock);
		rd(12'h098, 16'h0000);
		rd(12'h1c0, 16'h0020);
		wr(12'h068, 16'hffff);
		for (int s = 0; s < 6; s++) begin
			r = $urandom;
			seq_far_side_i.trig <= r;
			seq_far_side_i.pref <= ~r;
			seq_far_side_i.st <= 3'(s);
			repeat (3) @(posedge i_clock);
			rd(12'h068, r);
			rd(12'h070, ~r);
			rd(12'h080, 16'(s));
		end
		rde(12'h004, 16'h0000);
		rde(12'h069, r);
		$display("readback test done");
		a = $urandom;
		seq_far_side_i.list_end(1'h1, 1'h0, 1'h0, a);
		rd(12'h1c0, 16'h0038);
		rd(12'h078, a);
		rd(12'h1c0, 16'h0028);
		wr(12'h1c0, 16'hffff);
		seq_far_side_i.list_end(1'h1, 1'h0, 1'h1, ~a);
		rd(12'h078, a);
		rd(12'h1c0, 16'h0020);
		seq_far_side_i.list_end(1'h0, 1'h1, 1'h0, ~a);
		rd(12'h1c0, 16'h0030);
		rd(12'h078, ~a);
		i_new_addr_free <= 1'h0;
		rd(12'h1c0, 16'h0000);
		i_new_addr_free <= 1'h1;
		$display("list test done");
		r = $urandom;
		ev(r[9:0], 1'h1, 1'h1);
		rd(12'h1c0, {r[9:0], 6'h25});
		wr(12'h1c0, 16'hffff);
		ev(10'h000, 1'h1, 1'h0);
		wr(12'h1c0, 16'h0004);
		rd(12'h1c0, 16'h0020);
		foreach (sadr[k]) begin
			pq.push_back((k == 1 || k == 2) ? 3'h4 : 3'h2);
			seq_far_side_i.sum(1'h1, sadr[k], k == 4, 1'h0);
		end
		i_missed_trig_en <= 1'h1;
		pq.push_back(3'h3);
		seq_far_side_i.sum(1'h0, 16'h0300, 1'h0, 1'h1);
		i_missed_trig_en <= 1'h0;
		seq_far_side_i.sum(1'h0, 16'h0300, 1'h0, 1'h1);
		i_missed_trig_en <= 1'h1;
		seq_far_side_i.nsum <= 5'h00;
		seq_far_side_i.sum(1'h0, 16'h0300, 1'h0, 1'h1);
		i_missed_trig_en <= 1'h0;
		rd(12'h1c0, 16'h0022);
		$display("sum test done");
		for (int c = 0; c < 4; c++) begin
			r = (c == 0) ? 16'h0000 : 16'($urandom_range(20, 1));
			if (c == 1)
				wr(12'h088, r);
			if (c == 2)
				wr(12'h090, r);
			i_dt_wait0 <= (c == 1 || c == 2) ? 8'hff : r[7:0];
			i_dt_cfg <= 2'(c);
			i_dt_event <= 1'h1;
			@(posedge i_clock) i_dt_event <= 1'h0;
			n = 0;
			do begin
				@(negedge i_clock);
				n++;
			end while (o_sample_start !== 1'h1 && n < 300);
			chk("wait", r + 16'h1, n);
			@(posedge i_clock);
		end
		$display("dead time test done");
		r = $urandom;
		wr(12'h098, r);
		rd(12'h098, r);
		a = ~r;
		i_tadr_value <= a;
		i_tadr_load <= 1'h1;
		@(posedge i_clock) i_tadr_load <= 1'h0;
		@(negedge i_clock) chk("target", a, o_target_addr);
		@(posedge i_clock);
		r = {1'h0, 15'($urandom)};
		wr(12'h0a0, r);
		rd(12'h0a0, r);
		for (int k = 0; k < 7; k++) begin
			i_edge_trig <= k < 3 || k[0];
			i_auto_bit <= k < 3;
			i_edge_phase <= 2'(k % 3);
			i_ch_no <= 5'(k < 3 ? 3 : k < 6 ? 25 + k : 5);
			i_ch_req <= 1'h1;
			@(posedge i_clock) i_ch_req <= 1'h0;
			a = (k == 6) ? 16'h0005 : (r >> (5 * (k % 3))) & 16'h001f;
			@(negedge i_clock) chk("channel", a, o_conv_channel);
			@(posedge i_clock);
		end
		$display("target and channel test done");
		wr(12'h1c0, 16'hffff);
		wr(12'h1f0, 16'h0010);
		wr(12'h1e0, 16'h0003);
		wr(12'h1d0, 16'h0000);
		seq_far_side_i.list_end(1'h1, 1'h0, 1'h0, a);
		rd(12'h1f8, 16'h0010);
		irqchk(1'h0);
		wr(12'h1d0, 16'h0008);
		rd(12'h1f8, 16'h0003);
		irqchk(1'h1);
		wr(12'h1f0, 16'h0003);
		irqchk(1'h0);
		wr(12'h1f0, 16'h0004);
		irqchk(1'h1);
		wr(12'h1e8, 16'h0003);
		rd(12'h1f8, 16'h0010);
		irqchk(1'h0);
		wr(12'h1e0, 16'h0003);
		rd(12'h1e0, 16'h0000);
		wr(12'h1f8, 16'h0013);
		rd(12'h1f8, 16'h0003);
		wr(12'h1f8, 16'h0003);
		rd(12'h1f8, 16'h0010);
		rd(12'h1c0, 16'h0030);
		irqchk(1'h0);
		$display("interrupt test done");
		chk("queues", 33'h0, pq.size() + rq.size());
		complete_run;
	end
endmodule

bind adc_seq_status adc_seq_status_monitor adc_seq_status_monitor_i (
	.i_clock, .i_rst_b, .i_psel, .i_pwrite, .i_tadr_load, .i_tadr_value,
	.o_target_addr, .i_sum_req, .i_sum_addr, .i_wadr_min, .i_wadr_max,
	.i_fifo_overflow, .o_sum_write, .o_addr_skip, .i_missed_trig_en,
	.i_missed_dt_trigger, .i_no_sum, .o_marker_store, .o_marker_data
);

//--- sim/seq_far_side.sv
`timescale 1ns/100ps
module seq_far_side (
	input wire logic i_clock
);
	logic [15:0] trig = 16'h0000;
	logic [15:0] pref = 16'h0000;
	logic [15:0] sa = 16'h0000;
	logic [15:0] addr = 16'h0000;
	logic [2:0] st = 3'h0;
	logic [4:0] nsum = 5'h02;
	logic dn = 1'h0;
	logic go = 1'h0;
	logic sk = 1'h0;
	logic req = 1'h0;
	logic ovf = 1'h0;
	logic miss = 1'h0;

	// list end: start address is presented with the one-cycle pulse
	task automatic list_end(logic d, logic g, logic s, logic [15:0] a);
		sa <= a;
		dn <= d;
		go <= g;
		sk <= s;
		@(posedge i_clock) dn <= 1'h0;
		go <= 1'h0;
		sk <= 1'h0;
		@(posedge i_clock);
	endtask

	// address is not held past the request
	task automatic sum(logic r, logic [15:0] a, logic o, logic m);
		req <= r;
		addr <= a;
		ovf <= o;
		miss <= m;
		@(posedge i_clock) req <= 1'h0;
		ovf <= 1'h0;
		miss <= 1'h0;
		addr <= ~a;
		@(posedge i_clock);
	endtask
endmodule
